// ===== include/oef_consts.vh
// Purpose: constants for the otg event flag block
// Assumes: 50 MHz clock, 32-bit avalon data, byte addresses
// Notes: times kept in microseconds, cycle counts derived from them
`ifndef OEF_CONSTS_VH
`define OEF_CONSTS_VH

// register byte addresses
`define OEF_ADDR_FLAGS_RD 8'h68
`define OEF_ADDR_FLAGS_WR 8'hE8
`define OEF_ADDR_CTRL 8'h6C

// field positions in otg_event_flags
`define OEF_BIT_TIMER 10
`define OEF_BIT_SE0 9
`define OEF_BIT_SRP 8
`define OEF_BIT_RESUME 7
`define OEF_BIT_SUSPEND 6
`define OEF_BIT_STAT_HI 5
`define OEF_NUM_FLAGS 11
`define OEF_NUM_STATUS 6

// field position in otg_control_reg
`define OEF_BIT_REQ_SEL 9

// reset values
`define OEF_FLAGS_RST 11'h000
`define OEF_CTRL_RST 1'b0
`define OEF_ZERO32 32'h0000_0000

// timing
`define OEF_CLK_MHZ 50
`define OEF_SE0_TIME_US 2000
`define OEF_IDLE_TIME_US 3000
`define OEF_SE0_CYCLES (`OEF_SE0_TIME_US * `OEF_CLK_MHZ)
`define OEF_IDLE_CYCLES (`OEF_IDLE_TIME_US * `OEF_CLK_MHZ)

`endif

// ===== rtl/oef_duration_timer.v
// Purpose: measure how long a level has stood and flag when it passes a limit
// Assumes: cond is synchronous to clk
// Notes: over is a level, fired is a single pulse per stretch of cond
module oef_duration_timer #(
  parameter WIDTH = 32,
  parameter LIMIT = 100000
) (
  clk,
  rst,
  cond,
  over,
  fired
);
  input wire clk;
  input wire rst;
  input wire cond;
  output wire over;
  output wire fired;

  reg [WIDTH-1:0] count_r;
  reg over_r;
  wire [WIDTH-1:0] limit_w;

  assign limit_w = LIMIT[WIDTH-1:0];

  // counter saturates at the limit so it never wraps during long stretches
  always @(posedge clk)
  begin
    if (rst || !cond)
    begin
      count_r <= {WIDTH{1'b0}};
      over_r <= 1'b0;
    end
    else if (count_r != limit_w)
    begin
      count_r <= count_r + {{(WIDTH-1){1'b0}}, 1'b1};
    end
    else
    begin
      over_r <= 1'b1; // strictly longer than limit
    end
  end

  assign over = over_r;
  assign fired = cond && (count_r == limit_w) && !over_r;
endmodule // oef_duration_timer

// ===== rtl/oef_event_flags.v
// Purpose: sticky otg event flags with write-one-to-clear, on avalon-mm
// Assumes: all inputs synchronous to clk; line state is full speed (j = dp high)
// Notes: one wait state on every access; unmapped reads return zero
//
// Functional notes
// - read code 68h, write code E8h, same register
// - bit 10 set on otg timer expiry
// - writing one clears a flag, zero ignored
// - bit 9 set after se0 over 2 ms
// - bit 8 set on remote session request
// - control bit 9 picks supply or data pulsing
// - bit 7 set on j to k while suspended
// - bit 6 set on entering suspend, idle 3 ms
// - bits 5..0 set when status bits change
//
// Design decision made here: the Avalon-MM register port.
`include "oef_consts.vh"

module oef_event_flags #(
  parameter TIMER_WIDTH = 32,
  parameter SE0_CYCLES = `OEF_SE0_CYCLES,
  parameter IDLE_CYCLES = `OEF_IDLE_CYCLES
) (
  clk,
  rst,
  avs_address,
  avs_read,
  avs_write,
  avs_writedata,
  avs_byteenable,
  avs_readdata,
  avs_waitrequest,
  line_dp,
  line_dm,
  timer_timeout,
  srp_supply_pulse,
  srp_data_pulse,
  otg_status,
  suspended,
  request_type_select,
  otg_event_flags
);
  input wire clk;
  input wire rst;
  input wire [7:0] avs_address;
  input wire avs_read;
  input wire avs_write;
  input wire [31:0] avs_writedata;
  input wire [3:0] avs_byteenable;
  output reg [31:0] avs_readdata;
  output wire avs_waitrequest;
  input wire line_dp;
  input wire line_dm;
  input wire timer_timeout;
  input wire srp_supply_pulse;
  input wire srp_data_pulse;
  input wire [`OEF_NUM_STATUS-1:0] otg_status;
  output wire suspended;
  output wire request_type_select;
  output wire [`OEF_NUM_FLAGS-1:0] otg_event_flags;

  reg ack_r;
  reg [`OEF_NUM_FLAGS-1:0] flags_r;
  reg [`OEF_NUM_FLAGS-1:0] flags_nxt;
  reg [`OEF_NUM_FLAGS-1:0] set_w;
  reg [`OEF_NUM_FLAGS-1:0] clr_w;
  reg req_sel_r;
  reg suspend_r;
  reg line_k_r;
  reg [`OEF_NUM_STATUS-1:0] status_prev_r;
  wire req_w;
  wire wr_go;
  wire line_se0;
  wire line_j;
  wire line_k;
  wire se0_fired;
  wire idle_fired;
  wire srp_event;
  wire [15:0] wmask;
  wire [`OEF_NUM_STATUS-1:0] status_chg;

  // one wait state: request taken on first edge, answered on the next
  assign req_w = avs_read || avs_write;
  assign avs_waitrequest = req_w && !ack_r;
  assign wr_go = avs_write && ack_r;

  always @(posedge clk)
  begin
    if (rst)
      ack_r <= 1'b0;
    else
      ack_r <= req_w && !ack_r;
  end

  // read data is captured while waitrequest is high so it comes from a flop
  always @(posedge clk)
  begin
    if (rst)
      avs_readdata <= `OEF_ZERO32;
    else if (avs_read && !ack_r)
    begin
      avs_readdata <= `OEF_ZERO32;
      if (avs_address == `OEF_ADDR_FLAGS_RD)
        avs_readdata[`OEF_NUM_FLAGS-1:0] <= flags_r;
      else if (avs_address == `OEF_ADDR_CTRL)
        avs_readdata[`OEF_BIT_REQ_SEL] <= req_sel_r;
    end
  end

  // control register, only the request-type select bit is implemented
  always @(posedge clk)
  begin
    if (rst)
      req_sel_r <= `OEF_CTRL_RST;
    else if (wr_go && (avs_address == `OEF_ADDR_CTRL) && avs_byteenable[1])
      req_sel_r <= avs_writedata[`OEF_BIT_REQ_SEL];
  end

  // line decode; se0 holds both lines low
  assign line_se0 = !line_dp && !line_dm;
  assign line_j = line_dp && !line_dm;
  assign line_k = !line_dp && line_dm;

  oef_duration_timer #(
    .WIDTH(TIMER_WIDTH),
    .LIMIT(SE0_CYCLES)
  ) u_se0_timer (
    .clk(clk),
    .rst(rst),
    .cond(line_se0),
    .over(),
    .fired(se0_fired)
  );

  oef_duration_timer #(
    .WIDTH(TIMER_WIDTH),
    .LIMIT(IDLE_CYCLES)
  ) u_idle_timer (
    .clk(clk),
    .rst(rst),
    .cond(line_j),
    .over(),
    .fired(idle_fired)
  );

  // suspend state: entered after long idle, left on any non-idle line
  always @(posedge clk)
  begin
    if (rst)
    begin
      suspend_r <= 1'b0;
      line_k_r <= 1'b0;
    end
    else
    begin
      line_k_r <= line_k;
      if (idle_fired)
        suspend_r <= 1'b1;
      else if (!line_j && !line_k_r)
        suspend_r <= 1'b0; // clears on the first k too; resume is seen from suspend_r before this edge
    end
  end

  // status history has no reset, it samples otg_status every clock, so no change is reported on release
  always @(posedge clk)
  begin
    status_prev_r <= otg_status;
  end

  assign status_chg = otg_status ^ status_prev_r;
  assign srp_event = req_sel_r ? srp_data_pulse : srp_supply_pulse;

  // per-flag set and clear terms; set beats a clear in the same cycle
  assign wmask = {avs_byteenable[1] ? avs_writedata[15:8] : 8'h00,
                  avs_byteenable[0] ? avs_writedata[7:0] : 8'h00};

  always @*
  begin
    set_w = `OEF_FLAGS_RST;
    set_w[`OEF_BIT_TIMER] = timer_timeout;
    set_w[`OEF_BIT_SE0] = se0_fired;
    set_w[`OEF_BIT_SRP] = srp_event;
    set_w[`OEF_BIT_RESUME] = suspend_r && line_j_to_k(line_k, line_k_r);
    set_w[`OEF_BIT_SUSPEND] = idle_fired;
    set_w[`OEF_BIT_STAT_HI:0] = status_chg;
    clr_w = `OEF_FLAGS_RST;
    if (wr_go && (avs_address == `OEF_ADDR_FLAGS_WR))
      clr_w = wmask[`OEF_NUM_FLAGS-1:0];
    flags_nxt = (flags_r & ~clr_w) | set_w;
  end

  // k arriving where the previous sample was not k
  function line_j_to_k;
    input k_now;
    input k_prev;
    begin
      line_j_to_k = k_now && !k_prev;
    end
  endfunction

  always @(posedge clk)
  begin
    if (rst)
      flags_r <= `OEF_FLAGS_RST;
    else
      flags_r <= flags_nxt;
  end

  assign otg_event_flags = flags_r;
  assign suspended = suspend_r;
  assign request_type_select = req_sel_r;
endmodule // oef_event_flags

// ===== dv/oef_monitor.sv
// Purpose: port assertions for the otg event flags
// Assumes: one clock, sync reset
// Notes: flags checked one edge after their cause; suspend flag checked on the edge where suspended rises
module oef_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic line_dp,
  input wire logic line_dm,
  input wire logic timer_timeout,
  input wire logic srp_supply_pulse,
  input wire logic srp_data_pulse,
  input wire logic [5:0] otg_status,
  input wire logic suspended,
  input wire logic request_type_select,
  input wire logic [10:0] otg_event_flags
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // reset clears the flags; timer, srp, resume and suspend sources each leave a flag
  rst_zero_a: assert property ($fell(rst) |-> otg_event_flags == 11'h000) else $error("reset");
  tmr_set_a: assert property (timer_timeout |=> otg_event_flags[10]) else $error("timer");
  srp_set_a: assert property ((request_type_select ? srp_data_pulse : srp_supply_pulse)
    |=> otg_event_flags[8]) else $error("srp");
  resume_set_a: assert property (suspended && $rose(!line_dp && line_dm)
    |=> otg_event_flags[7]) else $error("resume");
  susp_set_a: assert property ($rose(suspended) |-> otg_event_flags[6]) else $error("suspend");
  // each toggled status bit must leave its own flag, not just any flag
  stat_set_a: assert property ($changed(otg_status)
    |=> (otg_event_flags[5:0] & ($past(otg_status) ^ $past(otg_status, 2)))
      == ($past(otg_status) ^ $past(otg_status, 2))) else $error("stat");
  // only a write may drop a flag
  flag_sticky_a: assert property (!avs_write
    |=> (otg_event_flags & $past(otg_event_flags)) == $past(otg_event_flags)) else $error("sticky");
  one_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("wait");
  cover property (avs_write && !avs_waitrequest);
  cover property ($rose(suspended));
  cover property (otg_event_flags[9]);
endmodule // oef_monitor

bind oef_event_flags oef_monitor u_mon (.clk(clk), .rst(rst), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .line_dp(line_dp), .line_dm(line_dm), .timer_timeout(timer_timeout),
  .srp_supply_pulse(srp_supply_pulse), .srp_data_pulse(srp_data_pulse), .otg_status(otg_status),
  .suspended(suspended), .request_type_select(request_type_select), .otg_event_flags(otg_event_flags));

// ===== dv/oef_remote.sv
// Purpose: remote otg device on the bus lines
// Assumes: full speed, j = dp high
// Notes: rests at k so no idle count runs between tests
module oef_remote (
  input wire logic clk,
  output logic line_dp,
  output logic line_dm,
  output logic srp_supply_pulse,
  output logic srp_data_pulse,
  output logic [5:0] otg_status
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {line_dp, line_dm, srp_supply_pulse, srp_data_pulse, otg_status} = 10'h100;
  // hold a line state n cycles, then back to k
  task automatic bus(input logic [1:0] s, input int n);
    {line_dp, line_dm} <= s;
    repeat (n) @(posedge clk);
    {line_dp, line_dm} <= 2'h1;
    @(posedge clk); // one k cycle, so a following call never drives the lines twice in one step
  endtask
  // one-cycle session request, data or supply kind
  task automatic srp(input logic d);
    if (d)
      srp_data_pulse <= 1'b1;
    else
      srp_supply_pulse <= 1'b1;
    @(posedge clk);
    {srp_data_pulse, srp_supply_pulse} <= 2'h0;
    @(posedge clk);
  endtask
  task automatic stat(input logic [5:0] v);
    otg_status <= v;
    repeat (2) @(posedge clk);
  endtask
endmodule // oef_remote

// ===== dv/tb.sv
// Purpose: self-checking bench for the otg event flags
// Assumes: short se0 and idle counts
// Notes: read words checked against a queue of notes
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, avs_read = 0, avs_write = 0, timer_timeout = 0;
  logic [7:0] avs_address = 8'h00;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, r;
  logic avs_waitrequest, line_dp, line_dm, srp_supply_pulse, srp_data_pulse, suspended, request_type_select;
  logic [5:0] otg_status;
  logic [10:0] otg_event_flags;
  logic [31:0] exp_q[$];
  int failures = 0, compares = 0, seed = 32'h98ae1710;
  always #10 clk = ~clk;
  oef_event_flags #(.SE0_CYCLES(20), .IDLE_CYCLES(30)) DUT (.clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .line_dp(line_dp), .line_dm(line_dm),
    .timer_timeout(timer_timeout), .srp_supply_pulse(srp_supply_pulse), .srp_data_pulse(srp_data_pulse),
    .otg_status(otg_status), .suspended(suspended), .request_type_select(request_type_select),
    .otg_event_flags(otg_event_flags));
  oef_remote peer (.clk(clk), .line_dp(line_dp), .line_dm(line_dm), .srp_supply_pulse(srp_supply_pulse),
    .srp_data_pulse(srp_data_pulse), .otg_status(otg_status));
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // hold the request until waitrequest is sampled low
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    {avs_address, avs_writedata, avs_write, avs_read} <= {a, d, w, !w};
    @(posedge clk);
    while (avs_waitrequest) @(posedge clk);
    {avs_write, avs_read} <= 2'h0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    acc(1'b0, a, 32'h0000_0000);
  endtask
  // each finished read against the oldest note
  always @(posedge clk)
    if (avs_read && !avs_waitrequest)
      check("readdata", avs_readdata, exp_q.pop_front());
  task automatic give_verdict;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    #100us;
    failures++;
    give_verdict;
  end
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    rd(8'h68, 32'h0000_0000);
    timer_timeout <= 1;
    @(posedge clk);
    timer_timeout <= 0;
    r = $random(seed) & 32'hffff_fbff;
    acc(1'b1, 8'he8, r);
    acc(1'b1, 8'h68, 32'hffff_ffff);
    rd(8'h68, 32'h0000_0400);
    acc(1'b1, 8'he8, 32'hffff_ffff);
    rd(8'h68, 32'h0000_0000);
    r = ($random(seed) & 32'h0000_003f) | 32'h0000_0001;
    peer.stat(otg_status ^ r[5:0]);
    rd(8'h68, r);
    // low lane disabled: the status flags must survive the clear
    avs_byteenable <= 4'he;
    acc(1'b1, 8'he8, r);
    rd(8'h68, r);
    avs_byteenable <= 4'hf;
    acc(1'b1, 8'he8, r);
    // wrong kind first, then the selected kind
    for (int i = 0; i < 2; i++)
    begin
      acc(1'b1, 8'h6c, {22'h0, i[0], 9'h0});
      peer.srp(!i[0]);
      peer.srp(i[0]);
      rd(8'h68, 32'h0000_0100);
      acc(1'b1, 8'he8, 32'h0000_0100);
    end
    rd(8'h6c, 32'h0000_0200);
    // se0 and idle at and just past their limits
    peer.bus(2'h0, 20);
    rd(8'h68, 32'h0000_0000);
    peer.bus(2'h0, 22);
    peer.bus(2'h2, 30);
    rd(8'h68, 32'h0000_0200);
    peer.bus(2'h2, 32);
    rd(8'h68, 32'h0000_02c0);
    give_verdict;
  end
endmodule // tb
